// ### inc/plma_pkg.sv
// Package for the programmable macrocell logic array: sizes, fuse map, types.
package plma_pkg;

    localparam int NUM_OUT = 10;
    localparam int NUM_DED = 12;
    localparam int NUM_SIG = 22;
    localparam int NUM_COL = 44;
    localparam int NUM_TERM = 132;
    localparam int MAX_PT = 16;
    localparam int TERM_OE_BASE = 120;
    localparam int TERM_SYNC_SET = 130;
    localparam int TERM_ASYNC_RST = 131;
    localparam int HI_BITS = 12;
    localparam int LO_BITS = 32;

    // Product-term counts per macrocell, 8 to 16, 120 in all.
    localparam int PT_CNT [NUM_OUT] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
    localparam int PT_BASE [NUM_OUT] = '{0, 8, 18, 30, 44, 60, 76, 90, 102,
        112};

    localparam logic FUSE_INTACT = 1'b0;
    localparam logic FUSE_BLOWN = 1'b1;

    localparam logic [11:0] ADDR_ROW_END = 12'h420;
    localparam logic [11:0] ADDR_CONFIG = 12'h800;
    localparam logic [11:0] ADDR_SECURITY = 12'h804;
    localparam logic [11:0] ADDR_PRELOAD = 12'h808;
    localparam logic [11:0] ADDR_STATUS = 12'h80C;
    localparam int ROW_IDX_LSB = 3;
    localparam int ROW_WORD_BIT = 2;
    localparam int CFG_FBM_LSB = 10;
    localparam int STAT_OE_LSB = 16;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } plma_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } plma_apb_rsp_t;

    typedef struct packed {
        logic [NUM_TERM-1:0][NUM_COL-1:0] fuse;
        logic [NUM_OUT-1:0] pol;
        logic [NUM_OUT-1:0] fbm;
        logic secure;
        logic [NUM_OUT-1:0] mq;
        logic [NUM_OUT-1:0] pin;
        logic [NUM_OUT-1:0] oe_n;
        logic [31:0] prdata;
        logic err;
        logic [1:0][NUM_DED-1:0] sync_in;
        logic [1:0][NUM_OUT-1:0] sync_io;
    } plma_state_t;

endpackage

// ### rtl/plma_array.sv
// Programmable sum-of-products array with ten configurable macrocells.
`timescale 1ns/10ps

module plma_array (
    input wire logic clk,
    input wire logic rst_n,
    input wire plma_pkg::plma_apb_req_t apb_req,
    output plma_pkg::plma_apb_rsp_t apb_rsp,
    input wire logic [plma_pkg::NUM_DED-1:0] in_pin,
    input wire logic [plma_pkg::NUM_OUT-1:0] io_in,
    output logic [plma_pkg::NUM_OUT-1:0] io_out,
    output logic [plma_pkg::NUM_OUT-1:0] io_oe_n
);

    plma_pkg::plma_state_t s_q;
    plma_pkg::plma_state_t s_d;

    logic [plma_pkg::NUM_SIG-1:0] sig;
    logic [plma_pkg::NUM_COL-1:0] cols;
    logic [plma_pkg::NUM_OUT-1:0] fb;
    logic [plma_pkg::NUM_OUT-1:0] sop;
    logic [plma_pkg::NUM_OUT-1:0] oe;
    logic sync_set;
    logic async_rst;

    // Pin feedback is read after the synchroniser, which breaks the
    // combinational loop a real pin would otherwise close.
    assign sig = {fb, s_q.sync_in[1]};

    genvar k;
    genvar o;
    genvar t;
    generate
        for (k = 0; k < plma_pkg::NUM_SIG; k++) begin : g_col
            assign cols[2*k] = sig[k];
            assign cols[2*k+1] = ~sig[k];
        end

        for (o = 0; o < plma_pkg::NUM_OUT; o++) begin : g_mc
            logic [plma_pkg::MAX_PT-1:0] hits;
            for (t = 0; t < plma_pkg::MAX_PT; t++) begin : g_pt
                if (t < plma_pkg::PT_CNT[o]) begin : g_used
                    // A blown fuse drops its column from the product.
                    assign hits[t] =
                        &(cols | s_q.fuse[plma_pkg::PT_BASE[o] + t]);
                end else begin : g_none
                    assign hits[t] = 1'b0;
                end
            end
            assign sop[o] = |hits;
            assign oe[o] =
                &(cols | s_q.fuse[plma_pkg::TERM_OE_BASE + o]);
            // Pin feedback lets a disabled pin act as an input.
            assign fb[o] = s_q.fbm[o] ? s_q.sync_io[1][o] : s_q.mq[o];
        end
    endgenerate

    assign sync_set = &(cols | s_q.fuse[plma_pkg::TERM_SYNC_SET]);
    assign async_rst = &(cols | s_q.fuse[plma_pkg::TERM_ASYNC_RST]);

    always_comb begin
        logic setup;
        logic access;
        logic [7:0] idx;
        logic row_hit;
        logic hi_word;
        setup = apb_req.psel & ~apb_req.penable;
        access = apb_req.psel & apb_req.penable;
        idx = apb_req.paddr[plma_pkg::ROW_IDX_LSB +: 8];
        row_hit = (apb_req.paddr < plma_pkg::ADDR_ROW_END);
        hi_word = apb_req.paddr[plma_pkg::ROW_WORD_BIT];

        s_d = s_q;
        s_d.sync_in[0] = in_pin;
        s_d.sync_in[1] = s_q.sync_in[0];
        s_d.sync_io[0] = io_in;
        s_d.sync_io[1] = s_q.sync_io[0];

        // Reset term beats set term; both act on every register.
        if (async_rst) begin
            s_d.mq = '0;
        end else if (sync_set) begin
            s_d.mq = '1;
        end else begin
            s_d.mq = sop;
        end

        // Register writes land in the access phase; pready is always high.
        if (access && apb_req.pwrite) begin
            if (row_hit) begin
                if (hi_word) begin
                    s_d.fuse[idx][plma_pkg::NUM_COL-1:plma_pkg::LO_BITS] =
                        apb_req.pwdata[plma_pkg::HI_BITS-1:0];
                end else begin
                    s_d.fuse[idx][plma_pkg::LO_BITS-1:0] = apb_req.pwdata;
                end
            end else if (apb_req.paddr == plma_pkg::ADDR_CONFIG) begin
                s_d.pol = apb_req.pwdata[plma_pkg::NUM_OUT-1:0];
                s_d.fbm = apb_req.pwdata[plma_pkg::CFG_FBM_LSB +:
                    plma_pkg::NUM_OUT];
            end else if (apb_req.paddr == plma_pkg::ADDR_SECURITY) begin
                // Blowing is one-way; only a device reset restores it.
                s_d.secure = s_q.secure | apb_req.pwdata[0];
            end else if (apb_req.paddr == plma_pkg::ADDR_PRELOAD) begin
                // Preload wins over the set and reset terms on its edge.
                s_d.mq = apb_req.pwdata[plma_pkg::NUM_OUT-1:0];
            end
        end

        // Read data and error are prepared in the setup phase.
        if (setup) begin
            s_d.err = 1'b0;
            s_d.prdata = '0;
            if (row_hit) begin
                if (s_q.secure) begin
                    s_d.prdata = hi_word ?
                        {{(plma_pkg::LO_BITS-plma_pkg::HI_BITS){1'b0}},
                         {plma_pkg::HI_BITS{plma_pkg::FUSE_BLOWN}}} :
                        {plma_pkg::LO_BITS{plma_pkg::FUSE_BLOWN}};
                end else if (hi_word) begin
                    s_d.prdata[plma_pkg::HI_BITS-1:0] =
                        s_q.fuse[idx][plma_pkg::NUM_COL-1:plma_pkg::LO_BITS];
                end else begin
                    s_d.prdata = s_q.fuse[idx][plma_pkg::LO_BITS-1:0];
                end
            end else if (apb_req.paddr == plma_pkg::ADDR_CONFIG) begin
                s_d.prdata[plma_pkg::NUM_OUT-1:0] =
                    s_q.secure ? '1 : s_q.pol;
                s_d.prdata[plma_pkg::CFG_FBM_LSB +: plma_pkg::NUM_OUT] =
                    s_q.secure ? '1 : s_q.fbm;
            end else if (apb_req.paddr == plma_pkg::ADDR_SECURITY) begin
                s_d.prdata[0] = s_q.secure;
            end else if (apb_req.paddr == plma_pkg::ADDR_PRELOAD) begin
                s_d.prdata[plma_pkg::NUM_OUT-1:0] = s_q.mq;
            end else if (apb_req.paddr == plma_pkg::ADDR_STATUS) begin
                s_d.prdata[plma_pkg::NUM_OUT-1:0] = s_q.pin;
                s_d.prdata[plma_pkg::STAT_OE_LSB +: plma_pkg::NUM_OUT] =
                    ~s_q.oe_n;
            end else begin
                s_d.err = 1'b1;
            end
        end

        // Pins are computed from the next register value so a registered
        // pin changes on the same edge as its register.
        for (int i = 0; i < plma_pkg::NUM_OUT; i++) begin
            if (s_q.fbm[i]) begin
                s_d.pin[i] = s_q.pol[i] ? sop[i] : ~sop[i];
            end else begin
                s_d.pin[i] = s_q.pol[i] ? s_d.mq[i] : ~s_d.mq[i];
            end
        end
        s_d.oe_n = ~oe;
    end

    // Reset clears every register and fuse; with polarity fuses intact an
    // active-low pin then reads high once enabled.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp.prdata = s_q.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = s_q.err;
    assign io_out = s_q.pin;
    assign io_oe_n = s_q.oe_n;

endmodule // plma_array

// ### test/plma_board.sv
// Board-side model that resolves each bidirectional pin.
`timescale 1ns/10ps
module plma_board (
    input wire logic [9:0] io_out,
    input wire logic [9:0] io_oe_n,
    input wire logic [9:0] drv,
    output logic [9:0] io_in
);
    // The board yields each pin that the device drives, so none contends.
    always_comb begin
        io_in = (io_oe_n & drv) | (~io_oe_n & io_out);
    end
endmodule // plma_board

// ### test/plma_sva.sv
// Checker for bus answers, hidden fuse readback and release from reset.
`timescale 1ns/10ps
module plma_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire plma_pkg::plma_apb_req_t apb_req,
    input wire plma_pkg::plma_apb_rsp_t apb_rsp,
    input wire logic [11:0] in_pin,
    input wire logic [9:0] io_in,
    input wire logic [9:0] io_out,
    input wire logic [9:0] io_oe_n
);
    logic sec_q;
    wire logic [11:0] a = apb_req.paddr;
    wire logic stp = apb_req.psel & ~apb_req.penable;
    wire logic bad = (a >= 12'h420 && a < 12'h800) || a > 12'h80C;
    wire logic lock = apb_req.psel && apb_req.penable && apb_req.pwrite
        && a == 12'h804 && apb_req.pwdata[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence rd_s; stp && !apb_req.pwrite && sec_q; endsequence
    // Sticky, so one write hides the fuse map until the next reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sec_q <= 1'b0;
        else sec_q <= sec_q | lock;
    end
    ready_a: assert property (apb_req.psel |-> apb_rsp.pready)
        else $error("pready low");
    unmapped_err_a: assert property (stp && bad |=> apb_rsp.pslverr)
        else $error("no slave error");
    mapped_ok_a: assert property (stp && !bad |=> !apb_rsp.pslverr)
        else $error("false slave error");
    read_hold_a: assert property (apb_req.psel && apb_req.penable
        |=> $stable(apb_rsp.prdata)) else $error("read data moved");
    hide_lo_a: assert property (rd_s ##0 (a < 12'h420 && !a[2])
        |=> apb_rsp.prdata == 32'hFFFFFFFF) else $error("row shown");
    hide_hi_a: assert property (rd_s ##0 (a < 12'h420 && a[2])
        |=> apb_rsp.prdata == 32'h00000FFF) else $error("row shown");
    hide_cfg_a: assert property (rd_s ##0 a == 12'h800
        |=> apb_rsp.prdata[19:0] == 20'hFFFFF) else $error("cfg shown");
    clear_a: assert property ($rose(rst_n)
        |=> io_out == 10'h3FF && io_oe_n == 10'h3FF) else $error("no clear");
endmodule // plma_sva
bind plma_array plma_sva plma_sva_inst (.clk, .rst_n, .apb_req, .apb_rsp,
    .in_pin, .io_in, .io_out, .io_oe_n);

// ### test/testbench.sv
// Self-checking bench for the macrocell array over APB and pins.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    plma_pkg::plma_apb_req_t req = '0;
    plma_pkg::plma_apb_rsp_t rsp;
    logic [11:0] in_pin = '0;
    logic [9:0] io_in, io_out, io_oe_n;
    logic [9:0] drv = '0;
    logic [32:0] exp_q[$];
    logic [63:0] m;
    logic [31:0] d;
    int err_total = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    plma_array plma_array_inst (.clk, .rst_n, .apb_req(req), .apb_rsp(rsp),
        .in_pin, .io_in, .io_out, .io_oe_n);
    plma_board plma_board_inst (.io_out, .io_oe_n, .drv, .io_in);
    always @(posedge clk) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready) begin
            `CHK({rsp.pslverr, rsp.prdata}, exp_q.pop_front())
        end
    end
    task give_verdict();
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic w, input logic [11:0] a, input logic [31:0] v);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, a, v};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            err_total++;
            give_verdict();
        end
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        wr(1'b0, a, '0);
    endtask
    task blow(input int r);
        wr(1'b1, 12'(8 * r), '1);
        wr(1'b1, 12'(8 * r + 4), '1);
    endtask
    task idle();
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task restart();
        req <= '0;
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    initial begin
        void'($urandom(32'h08C8B1C1));
        restart();
        in_pin <= 12'($urandom);
        drv <= 10'($urandom);
        rd(12'h80C, 33'h0000003FF);
        rd(12'h500, 33'h100000000);
        for (int k = 0; k < 4; k++) begin
            m = {$urandom, $urandom} & 64'h00000FFF_FFFFFFFF;
            d = 32'(8 * $urandom_range(131));
            wr(1'b1, d[11:0], m[31:0]);
            wr(1'b1, d[11:0] + 12'h4, m[63:32]);
            rd(d[11:0], {1'b0, m[31:0]});
            rd(d[11:0] + 12'h4, {1'b0, m[63:32]});
        end
        d = $urandom & 32'h000FFFFF;
        wr(1'b1, 12'h800, d);
        rd(12'h800, {1'b0, d});
        idle();
        restart();
        blow(0);
        blow(120);
        wr(1'b1, 12'h800, 32'h00000001);
        idle();
        rd(12'h80C, 33'h0000103FF);
        wr(1'b1, 12'h800, 32'h00000000);
        idle();
        rd(12'h80C, 33'h0000103FE);
        idle();
        restart();
        blow(130);
        idle();
        rd(12'h808, 33'h0000003FF);
        rd(12'h80C, 33'h000000000);
        blow(131);
        idle();
        rd(12'h808, 33'h000000000);
        rd(12'h80C, 33'h0000003FF);
        idle();
        restart();
        // Each cell's first term follows its own register, so it holds.
        for (int o = 0; o < 10; o++) begin
            m = ~(64'h1 << (24 + 2 * o));
            d = 32'(8 * plma_pkg::PT_BASE[o]);
            wr(1'b1, d[11:0], m[31:0]);
            wr(1'b1, d[11:0] + 12'h4, m[63:32] & 32'h00000FFF);
        end
        d = $urandom & 32'h000003FF;
        wr(1'b1, 12'h808, d);
        idle();
        rd(12'h808, {1'b0, d});
        rd(12'h80C, {1'b0, d ^ 32'h000003FF});
        // Cell 9 turns combinational; its first term reads its own pin.
        wr(1'b1, 12'h800, 32'h00080200);
        idle();
        rd(12'h80C, {1'b0, ((d ^ 32'h000003FF) & 32'h000001FF)
            | {22'h000000, drv[9], 9'h000}});
        wr(1'b1, 12'h804, 32'h00000001);
        rd(12'h000, 33'h0FFFFFFFF);
        rd(12'h004, 33'h000000FFF);
        idle();
        give_verdict();
    end
endmodule // testbench
